//--- bbs_defs.svh
// constants of the bring-up controller: offsets, fields, reset values, timing
`ifndef BBS_DEFS_SVH
`define BBS_DEFS_SVH
`define BBS_ADDR_SCR 8'h00
`define BBS_ADDR_MCR 8'h04
`define BBS_ADDR_DEC 8'h08
`define BBS_ADDR_ST0 8'h0c
`define BBS_ADDR_MASK0 8'h10
`define BBS_ADDR_ST1 8'h14
`define BBS_ADDR_MASK1 8'h18
`define BBS_ADDR_INTV 8'h1c
`define BBS_ADDR_STROBE 8'h20
`define BBS_ADDR_DEVADDR 8'h24
`define BBS_SCR_EVENT_RECEPTION_BIT 2
`define BBS_SCR_MAS 3
`define BBS_MCR_QO_LSB 4
`define BBS_MCR_MO_LSB 8
`define BBS_DEC_LINE 0
`define BBS_DEC_SLM 1
`define BBS_PIN_CLASS 16
`define BBS_MODE_RESET 3'h0
`define BBS_OFFS_RESET 4'h0
`define BBS_MASK0_RESET 2'h0
`define BBS_MASK1_RESET 4'h0
`define BBS_INTV_RESET 16'h0000
`define BBS_CLK_NS 20
`define BBS_STROBE_NS 100
`define BBS_STROBE_CYCLES ((`BBS_STROBE_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_STRAP_CYCLES 2'h3
`endif

//--- bbs_pkg.sv
// types of the bring-up controller
`default_nettype none
package bbs_pkg;
    typedef enum logic [1:0] {IL_RESET, IL_CONFIG, IL_LOOPBACK, IL_FULL} bbs_level_t;
endpackage : bbs_pkg
`default_nettype wire

//--- bbs_sup_if.sv
// link between the register block and the sink-time supervision timer
`timescale 1ns/1ps
`default_nettype none
interface bbs_sup_if;
    logic enable;
    logic [15:0] interval;
    logic tick;
    modport ctrl (output enable, output interval, input tick);
    modport timer (input enable, input interval, output tick);
endinterface : bbs_sup_if
`default_nettype wire

//--- bbs_sink_timer.sv
// sink-time supervision interval timer
`timescale 1ns/1ps
`default_nettype none
module bbs_sink_timer (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control from the register block
    bbs_sup_if.timer sup
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    // interval zero means off, so a half-configured node never floods memory
    always_comb begin
        nxt_cnt = 16'h0000;
        nxt_tick = 1'b0;
        if (sup.enable && sup.interval != 16'h0000) begin
            if (cnt_ff >= sup.interval - 16'h0001) begin
                nxt_tick = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign sup.tick = tick_ff;

    // ****************
    // checks
    // ****************
    tick_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
        tick_ff |-> $past(sup.enable))
        else $error("supervision tick without enable");
    tick_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (tick_ff && sup.interval > 16'h0001 && $stable(sup.interval)) |=> !tick_ff)
        else $error("supervision ticks too close");
endmodule : bbs_sink_timer
`default_nettype wire

//--- bbs_bringup.sv
// bring-up level controller with apb registers, strap, strobe and two irq lines
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bbs_defs.svh"
module bbs_bringup (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap and status pins
    input wire logic classModePin,
    input wire logic [11:0] deviceAddrInputs,
    input wire logic [3:0] extIrqInputsN,
    // outputs to the host
    output logic irqLine0N,
    output logic irqLine1N,
    output logic strobeN,
    output logic class1Mode
);
    // ****************
    // pin synchronisers
    // ****************
    logic [16:0] s1_ff, s2_ff, s3_ff, pinVal_ff;
    logic [16:0] nxt_pinVal;
    // a bit changes only once the second and third stages agree
    always_comb nxt_pinVal = (s2_ff & s3_ff) | (pinVal_ff & (s2_ff | s3_ff));
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // irq pins reset to their idle high level, else reset looks like an irq
            s1_ff <= 17'h0f000;
            s2_ff <= 17'h0f000;
            s3_ff <= 17'h0f000;
            pinVal_ff <= 17'h0f000;
        end else begin
            s1_ff <= {classModePin, extIrqInputsN, deviceAddrInputs};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            pinVal_ff <= nxt_pinVal;
        end
    end

    // ****************
    // strap capture
    // ****************
    logic [1:0] strapCnt_ff, nxt_strapCnt;
    logic strapDone_ff, nxt_strapDone;
    logic class1_ff, nxt_class1;
    // the strap is caught once, after the filter has settled, never under reset
    always_comb begin
        nxt_strapCnt = strapCnt_ff;
        nxt_strapDone = strapDone_ff;
        nxt_class1 = class1_ff;
        if (!strapDone_ff) begin
            nxt_strapCnt = strapCnt_ff + 2'h1;
            if (strapCnt_ff == `BBS_STRAP_CYCLES) begin
                nxt_strapDone = 1'b1;
                nxt_class1 = !nxt_pinVal[`BBS_PIN_CLASS];
            end
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strapCnt_ff <= 2'h0;
            strapDone_ff <= 1'b0;
            class1_ff <= 1'b0;
        end else begin
            strapCnt_ff <= nxt_strapCnt;
            strapDone_ff <= nxt_strapDone;
            class1_ff <= nxt_class1;
        end
    end

    // ****************
    // registers
    // ****************
    bbs_pkg::bbs_level_t level_ff, nxt_level;
    logic event_reception_bit_ff, nxt_event_reception_bit, mas_ff, nxt_mas, lineSel_ff, nxt_lineSel, slm_ff, nxt_slm;
    logic [2:0] memMode_ff, nxt_memMode;
    logic [3:0] qOff_ff, nxt_qOff, fOff_ff, nxt_fOff;
    logic [1:0] st0_ff, nxt_st0, mask0_ff, nxt_mask0;
    logic [3:0] st1_ff, nxt_st1, mask1_ff, nxt_mask1;
    logic [15:0] interval_ff, nxt_interval;
    logic [2:0] strobeCnt_ff, nxt_strobeCnt;
    logic [31:0] prdata_ff, nxt_prdata, rdVal;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, rdErr;
    logic irq0N_ff, nxt_irq0N, irq1N_ff, nxt_irq1N, strobeN_ff, nxt_strobeN;
    logic wrEn, strobeFire;
    logic [7:0] effAddr;
    bbs_sup_if supBus ();

    // class 1 keeps only the upper eight address pins as the address
    assign effAddr = class1_ff ? pinVal_ff[11:4] : pinVal_ff[7:0];
    assign wrEn = psel && penable && pready_ff && pwrite;
    assign supBus.enable = (level_ff == bbs_pkg::IL_LOOPBACK) || (level_ff == bbs_pkg::IL_FULL);
    assign supBus.interval = interval_ff;

    always_comb begin
        rdErr = 1'b0;
        case (paddr)
            `BBS_ADDR_SCR: rdVal = {27'h0000000, class1_ff, mas_ff, event_reception_bit_ff, level_ff};
            `BBS_ADDR_MCR: rdVal = {20'h00000, fOff_ff, qOff_ff, 1'b0,
                                    class1_ff ? 3'h0 : memMode_ff};
            `BBS_ADDR_DEC: rdVal = {30'h00000000, slm_ff, lineSel_ff};
            `BBS_ADDR_ST0: rdVal = {30'h00000000, st0_ff};
            `BBS_ADDR_MASK0: rdVal = {30'h00000000, mask0_ff};
            `BBS_ADDR_ST1: rdVal = {28'h0000000, st1_ff};
            `BBS_ADDR_MASK1: rdVal = {28'h0000000, mask1_ff};
            `BBS_ADDR_INTV: rdVal = {16'h0000, interval_ff};
            `BBS_ADDR_STROBE: rdVal = {31'h00000000, !strobeN_ff};
            `BBS_ADDR_DEVADDR: rdVal = {12'h000, effAddr, pinVal_ff[11:0]};
            default: begin
                rdVal = 32'h00000000;
                rdErr = 1'b1;
            end
        endcase
    end

    always_comb begin
        nxt_level = level_ff;
        nxt_event_reception_bit = event_reception_bit_ff;
        nxt_mas = mas_ff;
        nxt_memMode = memMode_ff;
        nxt_qOff = qOff_ff;
        nxt_fOff = fOff_ff;
        nxt_lineSel = lineSel_ff;
        nxt_slm = slm_ff;
        nxt_mask0 = mask0_ff;
        nxt_mask1 = mask1_ff;
        nxt_interval = interval_ff;
        nxt_strobeCnt = (strobeCnt_ff != 3'h0) ? strobeCnt_ff - 3'h1 : 3'h0;
        strobeFire = 1'b0;
        // status: a set in the same cycle as a clear wins
        nxt_st0 = st0_ff;
        nxt_st1 = st1_ff;
        if (wrEn) begin
            case (paddr)
                `BBS_ADDR_SCR: begin
                    nxt_level = bbs_pkg::bbs_level_t'(pwdata[1:0]);
                    nxt_event_reception_bit = pwdata[`BBS_SCR_EVENT_RECEPTION_BIT];
                    nxt_mas = pwdata[`BBS_SCR_MAS];
                end
                `BBS_ADDR_MCR: begin
                    nxt_memMode = pwdata[2:0];
                    nxt_qOff = pwdata[`BBS_MCR_QO_LSB +: 4];
                    nxt_fOff = pwdata[`BBS_MCR_MO_LSB +: 4];
                end
                `BBS_ADDR_DEC: begin
                    nxt_lineSel = pwdata[`BBS_DEC_LINE];
                    nxt_slm = pwdata[`BBS_DEC_SLM];
                end
                `BBS_ADDR_ST0: nxt_st0 = st0_ff & ~pwdata[1:0];
                `BBS_ADDR_MASK0: nxt_mask0 = pwdata[1:0];
                `BBS_ADDR_ST1: nxt_st1 = st1_ff & ~pwdata[3:0];
                `BBS_ADDR_MASK1: nxt_mask1 = pwdata[3:0];
                `BBS_ADDR_INTV: nxt_interval = pwdata[15:0];
                `BBS_ADDR_STROBE: begin
                    // a retrigger during a pulse is dropped to keep the width fixed
                    if (pwdata[0] && strobeCnt_ff == 3'h0) begin
                        nxt_strobeCnt = 3'(`BBS_STROBE_CYCLES);
                        strobeFire = 1'b1;
                    end
                end
                default: nxt_st0 = st0_ff;
            endcase
        end
        nxt_st0 = nxt_st0 | {strobeFire, supBus.tick};
        nxt_st1 = nxt_st1 | ~pinVal_ff[15:12];
        // level zero pins everything but the level, status and strobe bits at reset values
        if (level_ff == bbs_pkg::IL_RESET) begin
            nxt_event_reception_bit = 1'b0;
            nxt_mas = 1'b0;
            nxt_memMode = `BBS_MODE_RESET;
            nxt_qOff = `BBS_OFFS_RESET;
            nxt_fOff = `BBS_OFFS_RESET;
            nxt_lineSel = 1'b0;
            nxt_slm = 1'b0;
            nxt_mask0 = `BBS_MASK0_RESET;
            nxt_mask1 = `BBS_MASK1_RESET;
            nxt_interval = `BBS_INTV_RESET;
        end
        nxt_strobeN = (nxt_strobeCnt == 3'h0);
        nxt_irq0N = !(|(st0_ff & mask0_ff));
        nxt_irq1N = !(|(st1_ff & mask1_ff));
        // one wait state; no answer before the strap has settled
        nxt_pready = psel && penable && !pready_ff && strapDone_ff;
        nxt_prdata = nxt_pready ? rdVal : prdata_ff;
        nxt_pslverr = nxt_pready && rdErr;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_ff <= bbs_pkg::IL_RESET;
            memMode_ff <= `BBS_MODE_RESET;
            event_reception_bit_ff <= 1'b0;
            mas_ff <= 1'b0;
            qOff_ff <= `BBS_OFFS_RESET;
            fOff_ff <= `BBS_OFFS_RESET;
            lineSel_ff <= 1'b0;
            slm_ff <= 1'b0;
            st0_ff <= 2'h0;
            st1_ff <= 4'h0;
            mask0_ff <= `BBS_MASK0_RESET;
            mask1_ff <= `BBS_MASK1_RESET;
            interval_ff <= `BBS_INTV_RESET;
            strobeCnt_ff <= 3'h0;
            strobeN_ff <= 1'b1;
            irq0N_ff <= 1'b1;
            irq1N_ff <= 1'b1;
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            level_ff <= nxt_level;
            memMode_ff <= nxt_memMode;
            event_reception_bit_ff <= nxt_event_reception_bit;
            mas_ff <= nxt_mas;
            qOff_ff <= nxt_qOff;
            fOff_ff <= nxt_fOff;
            lineSel_ff <= nxt_lineSel;
            slm_ff <= nxt_slm;
            st0_ff <= nxt_st0;
            st1_ff <= nxt_st1;
            mask0_ff <= nxt_mask0;
            mask1_ff <= nxt_mask1;
            interval_ff <= nxt_interval;
            strobeCnt_ff <= nxt_strobeCnt;
            strobeN_ff <= nxt_strobeN;
            irq0N_ff <= nxt_irq0N;
            irq1N_ff <= nxt_irq1N;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    bbs_sink_timer u_sink_timer (
        .clk(clk),
        .reset_n(reset_n),
        .sup(supBus.timer)
    );

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irqLine0N = irq0N_ff;
    assign irqLine1N = irq1N_ff;
    assign strobeN = strobeN_ff;
    assign class1Mode = class1_ff;

    // ****************
    // checks
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence strobeLow;
        !strobeN_ff [*5] ##1 strobeN_ff;
    endsequence
    sequence belowLoop;
        (level_ff == bbs_pkg::IL_RESET || level_ff == bbs_pkg::IL_CONFIG) [*2];
    endsequence

    strap_class_a: assert property ($rose(strapDone_ff) |->
        class1_ff == !pinVal_ff[`BBS_PIN_CLASS] ##1 $stable(class1_ff))
        else $error("class strap not captured once");
    mode_zero_a: assert property ((pready_ff && psel && !pwrite && paddr == `BBS_ADDR_MCR
        && class1_ff) |-> prdata_ff[2:0] == 3'h0)
        else $error("memory mode not zero in class 1");
    reset_level_a: assert property (!strapDone_ff |->
        level_ff == bbs_pkg::IL_RESET && memMode_ff == 3'h0)
        else $error("not at level zero after reset");
    hold_regs_a: assert property (level_ff == bbs_pkg::IL_RESET |=>
        memMode_ff == 3'h0 && mask0_ff == 2'h0 && interval_ff == 16'h0000 && !mas_ff)
        else $error("register changed at level zero");
    sup_idle_a: assert property (belowLoop |-> !supBus.tick)
        else $error("supervision active below loopback");
    irq_line0_a: assert property (1'b1 |=> irq0N_ff == !$past(|(st0_ff & mask0_ff)))
        else $error("irq line 0 wrong");
    irq_line1_a: assert property (1'b1 |=> irq1N_ff == !$past(|(st1_ff & mask1_ff)))
        else $error("irq line 1 wrong");
    set_wins_a: assert property ((wrEn && paddr == `BBS_ADDR_ST0 && pwdata[0]
        && supBus.tick) |=> st0_ff[0])
        else $error("status set lost against clear");
    strobe_pulse_a: assert property ($fell(strobeN_ff) |-> strobeLow)
        else $error("strobe pulse width wrong");
endmodule : bbs_bringup
`default_nettype wire

//--- bbs_host_model.sv
// apb host model standing in for the host cpu of the bring-up controller
`timescale 1ns/1ps
`default_nettype none
module bbs_host_model (
    // clock
    input wire logic clk,
    // apb request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // apb answer
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // ************************************************
    // one transfer, held until pready is seen at an edge
    // ************************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // released data lines must not keep the old value
        pwdata <= ~d;
    endtask : apb
endmodule : bbs_host_model
`default_nettype wire

//--- tb_top.sv
// self-checking testbench of the bring-up controller
`timescale 1ns/1ps
`default_nettype none
`include "bbs_defs.svh"
module tb_top;
    logic clk = 1'b0;
    logic reset_n;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic classModePin;
    logic [11:0] deviceAddrInputs;
    logic [3:0] extIrqInputsN;
    logic irqLine0N, irqLine1N, strobeN, class1Mode;
    logic [32:0] expQ[$];
    logic [32:0] expRd;
    int errTotal = 0;
    int nTests = 0;
    int cnt;
    always #10 clk = ~clk;
    bbs_bringup u_bbs_bringup (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .classModePin(classModePin), .deviceAddrInputs(deviceAddrInputs),
        .extIrqInputsN(extIrqInputsN), .irqLine0N(irqLine0N), .irqLine1N(irqLine1N),
        .strobeN(strobeN), .class1Mode(class1Mode));
    bbs_host_model u_bbs_host_model (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));
    // ************************************************
    // checking
    // ************************************************
    task automatic chk(input string name, input logic [32:0] e, input logic [32:0] s);
        nTests++;
        if (s !== e) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", name, e, s);
        end
    endtask : chk
    task automatic giveVerdict;
        if (errTotal == 0 && nTests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : giveVerdict
    // read answers are matched against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
            expRd = expQ.pop_front();
            chk("read", expRd, {pslverr, prdata});
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_bbs_host_model.apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic err, input logic [31:0] e);
        expQ.push_back({err, e});
        u_bbs_host_model.apb(1'b0, a, $urandom);
    endtask : rd
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : waitc
    task automatic doReset(input logic cls);
        @(posedge clk);
        reset_n <= 1'b0;
        classModePin <= cls;
        deviceAddrInputs <= 12'($urandom);
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        waitc(6);
    endtask : doReset
    // ************************************************
    // scenarios
    // ************************************************
    initial begin
        rnd = $urandom(32'h5a2a4284);
        reset_n = 1'b0;
        classModePin = 1'b1;
        deviceAddrInputs = 12'($urandom);
        extIrqInputsN = 4'hf;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        waitc(6);
        chk("class1Mode", {32'h0, 1'b0}, {32'h0, class1Mode});
        rd(`BBS_ADDR_SCR, 1'b0, 32'h0);
        wr(`BBS_ADDR_MCR, 32'h0345);
        rd(`BBS_ADDR_MCR, 1'b0, 32'h0);
        wr(`BBS_ADDR_SCR, 32'h0d);
        rd(`BBS_ADDR_SCR, 1'b0, 32'h01);
        wr(`BBS_ADDR_SCR, 32'h0d);
        rd(`BBS_ADDR_SCR, 1'b0, 32'h0d);
        rnd = $urandom & 32'h0ff7;
        wr(`BBS_ADDR_MCR, rnd);
        rd(`BBS_ADDR_MCR, 1'b0, rnd);
        rd(`BBS_ADDR_DEVADDR, 1'b0, {12'h0, deviceAddrInputs[7:0], deviceAddrInputs});
        wr(`BBS_ADDR_DEC, 32'h1);
        wr(`BBS_ADDR_DEC, 32'h3);
        rd(`BBS_ADDR_DEC, 1'b0, 32'h3);
        rd(8'h40, 1'b1, 32'h0);
        wr(`BBS_ADDR_MASK0, 32'h2);
        wr(`BBS_ADDR_STROBE, 32'h1);
        #1;
        cnt = 0;
        while (strobeN === 1'b0 && cnt < 10) begin
            waitc(1);
            cnt++;
        end
        chk("strobe cycles", 33'h5, 33'(cnt));
        chk("irqLine0N", {32'h0, 1'b0}, {32'h0, irqLine0N});
        chk("irqLine1N", {32'h0, 1'b1}, {32'h0, irqLine1N});
        rd(`BBS_ADDR_ST0, 1'b0, 32'h2);
        wr(`BBS_ADDR_ST0, 32'h2);
        waitc(2);
        chk("irqLine0N", {32'h0, 1'b1}, {32'h0, irqLine0N});
        wr(`BBS_ADDR_MASK1, 32'h1);
        @(posedge clk);
        extIrqInputsN <= 4'he;
        waitc(8);
        chk("irqLine1N", {32'h0, 1'b0}, {32'h0, irqLine1N});
        chk("irqLine0N", {32'h0, 1'b1}, {32'h0, irqLine0N});
        @(posedge clk);
        extIrqInputsN <= 4'hf;
        waitc(6);
        wr(`BBS_ADDR_ST1, 32'h1);
        waitc(2);
        chk("irqLine1N", {32'h0, 1'b1}, {32'h0, irqLine1N});
        rd(`BBS_ADDR_ST1, 1'b0, 32'h0);
        wr(`BBS_ADDR_INTV, 32'h4);
        waitc(20);
        rd(`BBS_ADDR_ST0, 1'b0, 32'h0);
        wr(`BBS_ADDR_SCR, 32'h0e);
        waitc(20);
        rd(`BBS_ADDR_ST0, 1'b0, 32'h1);
        wr(`BBS_ADDR_INTV, 32'h1);
        wr(`BBS_ADDR_ST0, 32'h1);
        rd(`BBS_ADDR_ST0, 1'b0, 32'h1);
        wr(`BBS_ADDR_SCR, 32'h0f);
        rd(`BBS_ADDR_SCR, 1'b0, 32'h0f);
        wr(`BBS_ADDR_SCR, 32'h0);
        rd(`BBS_ADDR_MASK1, 1'b0, 32'h0);
        doReset(1'b0);
        chk("class1Mode", {32'h0, 1'b1}, {32'h0, class1Mode});
        rd(`BBS_ADDR_SCR, 1'b0, 32'h10);
        wr(`BBS_ADDR_SCR, 32'h1);
        wr(`BBS_ADDR_MCR, 32'h0345);
        rd(`BBS_ADDR_MCR, 1'b0, 32'h0340);
        rd(`BBS_ADDR_DEVADDR, 1'b0, {12'h0, deviceAddrInputs[11:4], deviceAddrInputs});
        waitc(2);
        giveVerdict();
    end
    // run takes under 1000 cycles; a hang is cut off well beyond that
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        giveVerdict();
    end
endmodule : tb_top
`default_nettype wire
